/* File: logic/ccg_map.svh */
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

// device register addresses and fields
`define CCG_PCC_ADDR 12'hFB3
`define CCG_SCC_ADDR 12'hFB7
`define CCG_PCC_RESET 4'h0
`define CCG_SCC_RESET 4'h0
`define CCG_PCC_HALT_BIT 2
`define CCG_PCC_STOP_BIT 3
`define CCG_SCC_SRC_BIT 0
`define CCG_SCC_OSC_BIT 3
`define CCG_PCC_SLOW_SUB 4'h1

// divider terminal counts (ratio minus one)
`define CCG_DIV64_LAST 6'h3F
`define CCG_DIV16_LAST 6'h0F
`define CCG_DIV8_LAST 6'h07
`define CCG_DIV4_LAST 6'h03
`define CCG_SUB_DIV_LAST 2'h3
`define CCG_PERIPH_PHASE 2'h3

// machine cycles to wait after switching to the subsystem clock
`define CCG_SWITCH_WAIT 6'h20

// controller register byte offsets and fields
`define CCG_CMD_OFS 4'h0
`define CCG_STATUS_OFS 4'h4
`define CCG_CFG_OFS 4'h8
`define CCG_CMD_DATA_LSB 0
`define CCG_CMD_BIT_LSB 4
`define CCG_CMD_OP_LSB 6
`define CCG_CMD_ADDR_LSB 9
`define CCG_ST_REFUSED_BIT 8
`define CCG_ST_SETTLED_BIT 9
`define CCG_CFG_RESET 1'h0

`endif

/* File: logic/ccg_pkg.sv */
package ccg_pkg;
  // operations passed from the controller to the device
  typedef enum logic [2:0] {
    CCG_OP_WR4 = 3'b000,
    CCG_OP_SET = 3'b001,
    CCG_OP_CLR = 3'b010,
    CCG_OP_HALT = 3'b011,
    CCG_OP_STOP = 3'b100
  } ccg_op_t;
endpackage : ccg_pkg

/* File: logic/ccg_link_if.sv */
`timescale 1ns/1ps
interface ccg_link_if;
  import ccg_pkg::*;
  logic opValid;
  ccg_op_t opKind;
  logic [11:0] opAddr;
  logic [3:0] opData;
  logic [1:0] opBit;
  logic wake;
  logic [3:0] pccState;
  logic [3:0] sccState;
  logic machTick;

  modport dev (
    input opValid, opKind, opAddr, opData, opBit, wake,
    output pccState, sccState, machTick
  );
  modport ctl (
    output opValid, opKind, opAddr, opData, opBit, wake,
    input pccState, sccState, machTick
  );
endinterface : ccg_link_if

/* File: logic/ccg_device.sv */
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_device
  import ccg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ccg_link_if.dev link,
  input wire logic subClkPin,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic watchClkEn,
  output logic mainOscRun,
  output logic mainOscGnd,
  output logic standbyMode
);

  logic [3:0] pcc_r;
  logic [3:0] pcc_nxt;
  logic [3:0] scc_r;
  logic [3:0] scc_nxt;
  logic [1:0] actDiv_r;
  logic actSrc_r;
  logic [5:0] mainCnt_r;
  logic [5:0] divLast;
  logic [1:0] subCnt_r;
  logic subMeta_r;
  logic subSync2_r;
  logic subSync3_r;
  logic subLevel_r;
  logic subRise;
  logic tickMain;
  logic tickSub;
  logic tick;
  logic machTick_r;
  logic pccHit;
  logic sccHit;

  // the bank flag plays no part in decode, only the address does
  assign pccHit = link.opValid && (link.opAddr == `CCG_PCC_ADDR);
  assign sccHit = link.opValid && (link.opAddr == `CCG_SCC_ADDR);

  // processor clock register next value; instructions win over a release
  always_comb begin
    pcc_nxt = pcc_r;
    if (link.wake) begin
      pcc_nxt[`CCG_PCC_STOP_BIT] = 1'b0;
      pcc_nxt[`CCG_PCC_HALT_BIT] = 1'b0;
    end
    if (pccHit && link.opKind == CCG_OP_WR4) begin
      pcc_nxt = {2'b00, link.opData[1:0]};
    end
    // the mode field never reaches the reserved code 11
    if (link.opValid && link.opKind == CCG_OP_HALT && !pcc_r[`CCG_PCC_STOP_BIT]) begin
      pcc_nxt[`CCG_PCC_HALT_BIT] = 1'b1;
    end
    if (link.opValid && link.opKind == CCG_OP_STOP && !actSrc_r && !pcc_r[`CCG_PCC_HALT_BIT]) begin
      pcc_nxt[`CCG_PCC_STOP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcc_r <= `CCG_PCC_RESET;
    end else begin
      pcc_r <= pcc_nxt;
    end
  end

  // system clock register: single-bit operations only, reserved combination refused
  always_comb begin
    scc_nxt = scc_r;
    if (sccHit && link.opKind == CCG_OP_SET) begin
      if (link.opBit == 2'h0) begin
        scc_nxt[`CCG_SCC_SRC_BIT] = 1'b1;
      end else if (link.opBit == 2'h3 && scc_r[`CCG_SCC_SRC_BIT]) begin
        scc_nxt[`CCG_SCC_OSC_BIT] = 1'b1;
      end
    end else if (sccHit && link.opKind == CCG_OP_CLR) begin
      if (link.opBit == 2'h3) begin
        scc_nxt[`CCG_SCC_OSC_BIT] = 1'b0;
      end else if (link.opBit == 2'h0 && !scc_r[`CCG_SCC_OSC_BIT]) begin
        scc_nxt[`CCG_SCC_SRC_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scc_r <= `CCG_SCC_RESET;
    end else begin
      scc_r <= scc_nxt;
    end
  end

  // subsystem pin synchroniser; level accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      subMeta_r <= 1'b0;
      subSync2_r <= 1'b0;
      subSync3_r <= 1'b0;
      subLevel_r <= 1'b0;
    end else begin
      subMeta_r <= subClkPin;
      subSync2_r <= subMeta_r;
      subSync3_r <= subSync2_r;
      if (subSync2_r == subSync3_r) begin
        subLevel_r <= subSync3_r;
      end
    end
  end

  assign subRise = (subSync2_r == subSync3_r) && subSync3_r && !subLevel_r;

  // subsystem divide-by-four; it has no stop control at all
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      subCnt_r <= 2'h0;
    end else if (subRise) begin
      subCnt_r <= subCnt_r + 2'h1;
    end
  end

  assign tickSub = subRise && (subCnt_r == `CCG_SUB_DIV_LAST);

  // main divider terminal count from the divider latched at the boundary
  always_comb begin
    case (actDiv_r)
      2'b00: divLast = `CCG_DIV64_LAST;
      2'b01: divLast = `CCG_DIV16_LAST;
      2'b10: divLast = `CCG_DIV8_LAST;
      default: divLast = `CCG_DIV4_LAST;
    endcase
  end

  assign tickMain = mainOscRun && (mainCnt_r == divLast);
  // the divider bits are ignored while the subsystem source is active
  assign tick = actSrc_r ? tickSub : tickMain;

  // main divider; held at zero while the main oscillator is stopped, and restarted at every
  // machine cycle edge so the first main cycle after leaving the subsystem source is whole
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mainCnt_r <= 6'h00;
    end else if (!mainOscRun || tickMain || tick) begin
      mainCnt_r <= 6'h00;
    end else begin
      mainCnt_r <= mainCnt_r + 6'h01;
    end
  end

  // new divider and source only at a machine cycle edge, so no runt CPU pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      actDiv_r <= 2'b00;
      actSrc_r <= 1'b0;
    end else if (tick) begin
      actDiv_r <= pcc_r[1:0];
      actSrc_r <= scc_r[`CCG_SCC_SRC_BIT];
    end
  end

  // oscillator control; on main source the oscillator stop bit only drives mainOscGnd, and stops nothing until the switch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mainOscRun <= 1'b1;
      mainOscGnd <= 1'b0;
    end else begin
      mainOscRun <= !pcc_nxt[`CCG_PCC_STOP_BIT] && !(scc_nxt[`CCG_SCC_OSC_BIT] && actSrc_r);
      mainOscGnd <= scc_nxt[`CCG_SCC_OSC_BIT];
    end
  end

  // clock enables; CPU gated in either standby mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuClkEn <= 1'b0;
      machTick_r <= 1'b0;
      periphClkEn <= 1'b0;
      watchClkEn <= 1'b0;
      standbyMode <= 1'b0;
    end else begin
      cpuClkEn <= tick && (pcc_r[3:2] == 2'b00);
      machTick_r <= tick;
      // every ratio is a multiple of four, so the low counter bits run mod four
      periphClkEn <= mainOscRun && !actSrc_r && (mainCnt_r[1:0] == `CCG_PERIPH_PHASE);
      watchClkEn <= subRise;
      standbyMode <= (pcc_nxt[3:2] != 2'b00);
    end
  end

  assign link.pccState = pcc_r;
  assign link.sccState = scc_r;
  assign link.machTick = machTick_r;

endmodule : ccg_device

/* File: logic/ccg_ctrl.sv */
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_ctrl
  import ccg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ccg_link_if.ctl link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wakeReq
);

  logic accept;
  logic cmdHit;
  logic [3:0] cData;
  logic [1:0] cBit;
  ccg_op_t cOp;
  logic [11:0] cAddr;
  logic refuse;
  logic settled;
  logic refused_r;
  logic extMainClk_r;
  logic [5:0] waitCnt_r;
  logic opValid_r;
  ccg_op_t opKind_r;
  logic [11:0] opAddr_r;
  logic [3:0] opData_r;
  logic [1:0] opBit_r;
  logic wake_r;

  // one wait cycle per access; the request is taken when waitrequest is low
  assign accept = (avs_read || avs_write) && !avs_waitrequest;
  assign cmdHit = accept && avs_write && (avs_address == `CCG_CMD_OFS);
  assign cData = avs_writedata[`CCG_CMD_DATA_LSB +: 4];
  assign cBit = avs_writedata[`CCG_CMD_BIT_LSB +: 2];
  assign cOp = ccg_op_t'(avs_writedata[`CCG_CMD_OP_LSB +: 3]);
  assign cAddr = avs_writedata[`CCG_CMD_ADDR_LSB +: 12];
  assign settled = (waitCnt_r == `CCG_SWITCH_WAIT);

  // software guard: commands that would break the clock switching discipline
  always_comb begin
    refuse = 1'b0;
    if (cAddr == `CCG_SCC_ADDR && cOp == CCG_OP_WR4) begin
      refuse = 1'b1;
    end else if (cAddr == `CCG_SCC_ADDR && cOp == CCG_OP_SET && cBit == 2'h0
                 && link.pccState == `CCG_PCC_SLOW_SUB) begin
      refuse = 1'b1;
    end else if (cAddr == `CCG_PCC_ADDR && cOp == CCG_OP_WR4 && link.sccState[`CCG_SCC_SRC_BIT]
                 && {2'b00, cData[1:0]} == `CCG_PCC_SLOW_SUB) begin
      refuse = 1'b1;
    end else if (cAddr == `CCG_SCC_ADDR && cOp == CCG_OP_SET && cBit == 2'h3
                 && (!settled || extMainClk_r)) begin
      refuse = 1'b1;
    end
  end

  // waitrequest toggles low for one cycle after a request appears
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data prepared while waitrequest is high, valid at the accepting edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      if (avs_address == `CCG_STATUS_OFS) begin
        avs_readdata <= {22'h000000, settled, refused_r, link.sccState, link.pccState};
      end else if (avs_address == `CCG_CFG_OFS) begin
        avs_readdata <= {31'h00000000, extMainClk_r};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  // configuration and sticky refusal flag; a new refusal wins over the read-clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extMainClk_r <= `CCG_CFG_RESET;
      refused_r <= 1'b0;
    end else begin
      if (accept && avs_write && avs_address == `CCG_CFG_OFS) begin
        extMainClk_r <= avs_writedata[0];
      end
      if (cmdHit && refuse) begin
        refused_r <= 1'b1;
      end else if (accept && avs_read && avs_address == `CCG_STATUS_OFS) begin
        refused_r <= 1'b0;
      end
    end
  end

  // machine cycles spent on the subsystem source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt_r <= 6'h00;
    end else if (!link.sccState[`CCG_SCC_SRC_BIT]) begin
      waitCnt_r <= 6'h00;
    end else if (link.machTick && !settled) begin
      waitCnt_r <= waitCnt_r + 6'h01;
    end
  end

  // operation issue toward the device, one pulse per accepted command that the guard does not refuse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opValid_r <= 1'b0;
      opKind_r <= CCG_OP_WR4;
      opAddr_r <= 12'h000;
      opData_r <= 4'h0;
      opBit_r <= 2'h0;
      wake_r <= 1'b0;
    end else begin
      opValid_r <= cmdHit && !refuse;
      if (cmdHit) begin
        opKind_r <= cOp;
        opAddr_r <= cAddr;
        opData_r <= cData;
        opBit_r <= cBit;
      end
      wake_r <= wakeReq;
    end
  end

  assign link.opValid = opValid_r;
  assign link.opKind = opKind_r;
  assign link.opAddr = opAddr_r;
  assign link.opData = opData_r;
  assign link.opBit = opBit_r;
  assign link.wake = wake_r;

endmodule : ccg_ctrl

/* File: dv/ccg_link_asserts.sv */
`timescale 1ns/1ps
`include "ccg_map.svh"
module ccg_link_asserts
  import ccg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire ccg_op_t opKind,
  input wire logic [11:0] opAddr,
  input wire logic [3:0] opData,
  input wire logic [1:0] opBit,
  input wire logic wake,
  input wire logic [3:0] pccState,
  input wire logic [3:0] sccState,
  input wire logic machTick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // address decode shared by the properties
  wire pccOp = opValid && opAddr == `CCG_PCC_ADDR;
  wire sccOp = opValid && opAddr == `CCG_SCC_ADDR;
  // one machine cycle at main /4: tick, three quiet edges, tick; a stop entered inside it freezes the divider
  sequence s_fast_cycle;
    machTick ##1 !machTick [*3] ##1 (machTick || pccState[3]);
  endsequence
  a_wr4_mode_zero: assert property (pccOp && opKind == CCG_OP_WR4 |=> pccState == {2'b00, $past(opData[1:0])})
    else $error("divider write did not clear mode");
  a_halt_sets_bit: assert property (opValid && opKind == CCG_OP_HALT && !pccState[3] |=> pccState[2])
    else $error("halt bit not set");
  a_stop_on_main: assert property (opValid && opKind == CCG_OP_STOP && !pccState[2] && !sccState[0] |=> pccState[3])
    else $error("stop bit not set");
  a_stop_sub_refused: assert property (opValid && opKind == CCG_OP_STOP && sccState[0] && !pccState[3] |=> !pccState[3])
    else $error("stop entered on subsystem clock");
  a_wake_clears_mode: assert property (wake && !opValid |=> pccState[3:2] == 2'b00)
    else $error("release left mode bits set");
  a_src_clear_guard: assert property (sccOp && opKind == CCG_OP_CLR && opBit == 2'h0 && sccState[3] |=> $stable(sccState))
    else $error("source bit changed with oscillator stopped");
  a_osc_main_refused: assert property (sccOp && opKind == CCG_OP_SET && opBit == 2'h3 && !sccState[0] |=> $stable(sccState))
    else $error("oscillator stop taken on main clock");
  a_scc_legal: assert property (sccState[2:1] == 2'b00 && !(sccState[3] && !sccState[0]))
    else $error("reserved system clock setting");
  a_mode_legal: assert property (pccState[3:2] != 2'b11)
    else $error("reserved mode code");
  // the pcc check one edge back keeps a pending divider change out of the window
  a_fast_tick: assert property (machTick && pccState[1:0] == 2'b11 && $past(pccState[1:0]) == 2'b11
    && !sccState[0] && !$past(sccState[0]) |-> s_fast_cycle)
    else $error("main /4 machine cycle not four clocks");
endmodule : ccg_link_asserts

/* File: dv/tb_cpu_clock_generator_control.sv */
`timescale 1ns/1ps
`include "ccg_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_cpu_clock_generator_control
  import ccg_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, subClkPin = 0, avs_read = 0, avs_write = 0, wakeReq = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, cpuClkEn, periphClkEn, watchClkEn, mainOscRun, mainOscGnd, standbyMode;
  int fail_count = 0, comparisons = 0, cpuCnt = 0, perCnt = 0, watCnt = 0, sd = 0;
  ccg_link_if link ();
  ccg_device u_ccg_device (.ref_clk, .rst_n, .link(link.dev), .subClkPin, .cpuClkEn, .periphClkEn,
    .watchClkEn, .mainOscRun, .mainOscGnd, .standbyMode);
  ccg_ctrl u_ccg_ctrl (.ref_clk, .rst_n, .link(link.ctl), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .wakeReq);
  ccg_link_asserts u_ccg_link_asserts (.ref_clk, .rst_n, .opValid(link.opValid), .opKind(link.opKind),
    .opAddr(link.opAddr), .opData(link.opData), .opBit(link.opBit), .wake(link.wake),
    .pccState(link.pccState), .sccState(link.sccState), .machTick(link.machTick));
  initial forever #4 ref_clk = ~ref_clk;
  // subsystem pin: period of ten main clocks, unrelated to any divider
  always @(posedge ref_clk) begin
    sd <= (sd == 4) ? 0 : sd + 1;
    if (sd == 4) subClkPin <= ~subClkPin;
    cpuCnt <= cpuCnt + (cpuClkEn === 1'b1);
    perCnt <= perCnt + (periphClkEn === 1'b1);
    watCnt <= watCnt + (watchClkEn === 1'b1);
  end
  task automatic close_out;
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic hang;
    fail_count++;
    close_out();
  endtask : hang
  // one avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic st;
    bus(1'b0, `CCG_STATUS_OFS, 32'h0);
  endtask : st
  task automatic cmd(input ccg_op_t op, input logic [11:0] a, input logic [1:0] b, input logic [3:0] d);
    bus(1'b1, `CCG_CMD_OFS, {11'h0, a, op, b, d});
  endtask : cmd
  task automatic wake;
    @(posedge ref_clk) wakeReq <= 1'b1;
    @(posedge ref_clk) wakeReq <= 1'b0;
  endtask : wake
  // clocks from one machine tick to the next
  task automatic per(output int p);
    int n;
    n = 0;
    p = 0;
    do begin @(posedge ref_clk); n++; end while (link.machTick !== 1'b1 && n < 300);
    do begin @(posedge ref_clk); p++; end while (link.machTick !== 1'b1 && p < 300);
    if (p >= 300) hang();
  endtask : per
  task automatic t_reset;
    int c;
    st();
    `CHK(q[8:0], 9'h000)
    `CHK(mainOscRun, 1'b1)
    // main source: one peripheral strobe every four clocks
    c = perCnt;
    repeat (40) @(posedge ref_clk);
    `CHK(perCnt - c, 10)
  endtask : t_reset
  // mode bits written as ones must come back as zero
  task automatic t_divider;
    int p;
    for (int k = 0; k < 4; k++) begin
      cmd(CCG_OP_WR4, `CCG_PCC_ADDR, 2'h0, {2'b11, k[1:0]});
      st();
      `CHK(q[3:0], {2'b00, k[1:0]})
      per(p);
      per(p);
      `CHK(p, (k == 0) ? 64 : (k == 1) ? 16 : (k == 2) ? 8 : 4)
    end
  endtask : t_divider
  task automatic t_standby(input ccg_op_t op, input logic [3:0] e);
    int c;
    cmd(op, `CCG_PCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[3:0], e)
    `CHK(standbyMode, 1'b1)
    if (e[3]) `CHK(mainOscRun, 1'b0)
    c = cpuCnt;
    repeat (20) @(posedge ref_clk);
    `CHK(cpuCnt - c, 0)
    wake();
    st();
    `CHK(q[3:0], e & 4'h3)
    `CHK(standbyMode, 1'b0)
    // a released CPU must be clocked again, not merely show clear mode bits
    c = cpuCnt;
    repeat (40) @(posedge ref_clk);
    `CHK(cpuCnt != c, 1'b1)
  endtask : t_standby
  task automatic t_sub;
    int p, c, w, n;
    cmd(CCG_OP_SET, `CCG_SCC_ADDR, 2'h3, 4'h0);
    st();
    `CHK(q[8:4], 5'h10)
    `CHK(mainOscRun, 1'b1)
    cmd(CCG_OP_SET, `CCG_SCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[8:4], 5'h01)
    per(p);
    per(p);
    `CHK(p, 40)
    c = perCnt;
    w = watCnt;
    repeat (40) @(posedge ref_clk);
    `CHK(perCnt - c, 0)
    `CHK(watCnt - w, 4)
    cmd(CCG_OP_STOP, `CCG_PCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[3:0], 4'h3)
    n = 0;
    do begin st(); n++; end while (q[9] !== 1'b1 && n < 600);
    if (n >= 600) hang();
    cmd(CCG_OP_SET, `CCG_SCC_ADDR, 2'h3, 4'h0);
    cmd(CCG_OP_CLR, `CCG_SCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[7:4], 4'h9)
    `CHK(mainOscGnd, 1'b1)
    `CHK(mainOscRun, 1'b0)
    t_standby(CCG_OP_HALT, 4'h7);
    cmd(CCG_OP_CLR, `CCG_SCC_ADDR, 2'h3, 4'h0);
    cmd(CCG_OP_CLR, `CCG_SCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[7:4], 4'h0)
    `CHK(mainOscGnd, 1'b0)
    `CHK(mainOscRun, 1'b1)
  endtask : t_sub
  task automatic t_refuse;
    cmd(CCG_OP_WR4, `CCG_PCC_ADDR, 2'h0, 4'h1);
    cmd(CCG_OP_SET, `CCG_SCC_ADDR, 2'h0, 4'h0);
    st();
    `CHK(q[8:4], 5'h10)
    cmd(CCG_OP_WR4, `CCG_SCC_ADDR, 2'h0, 4'h9);
    st();
    `CHK(q[8:4], 5'h10)
    bus(1'b0, 4'hC, 32'h0);
    `CHK(q, 32'h0)
  endtask : t_refuse
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_divider();
    t_standby(CCG_OP_HALT, 4'h7);
    t_standby(CCG_OP_STOP, 4'hB);
    t_sub();
    t_refuse();
    close_out();
  end
endmodule : tb_cpu_clock_generator_control
